// ---- src/cgi_pkg.sv ----
package cgi_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Configuration byte bank of the target
  localparam int       REG_COUNT      = 16;
  localparam logic [7:0] GCTRL_IDX    = 8'h00;
  localparam int       GC_OTP_DONE    = 7;
  localparam int       GC_ADDR_MSB    = 6;
  localparam int       GC_ADDR_LSB    = 5;
  localparam int       GC_SPREAD      = 4;
  localparam int       GC_REFSEL      = 2;
  localparam int       GC_LOCK        = 0;
  localparam logic [7:0] GCTRL_RESET  = 8'h00;
  localparam logic [7:0] GCTRL_WMASK  = 8'hf5;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [6:0] DEV_ADDR_BASE = 7'h68;

  ////////////////////////////////////////////////////////////////////////////
  // Controller command registers
  localparam logic [7:0] HR_CMD       = 8'h00;
  localparam logic [7:0] HR_STATUS    = 8'h01;
  localparam logic [7:0] HR_TARGET    = 8'h02;
  localparam logic [7:0] HR_INDEX     = 8'h03;
  localparam logic [7:0] HR_COUNT     = 8'h04;
  localparam logic [7:0] HR_RXCOUNT   = 8'h05;
  localparam logic [7:0] HR_BUF       = 8'h10;
  localparam int       CMD_GO         = 0;
  localparam int       CMD_READ       = 1;
  localparam int       STS_BUSY       = 0;
  localparam int       STS_NACK       = 1;
  localparam int       HOST_BUF_DEPTH = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: serial clock is four quarters of at least this many cycles
  localparam int       CLK_PERIOD_NS  = 8;
  localparam int       SCL_PERIOD_NS  = 10000;
  localparam int       SCL_MAX_KHZ    = 400;
  localparam int       QTR_CYC        = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : cgi_pkg

// ---- src/cgi_link_if.sv ----
`timescale 1ns/1ps
interface cgi_link_if;
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic scl;
  logic sda;

  // Wired-AND of both ends on sda, scl from the controller only; a released line floats high on the pull-up
  assign scl = ~(hostSclOe & ~hostSclOut);
  assign sda = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));

  modport dev_mp (input scl, input sda, output devSdaOut, output devSdaOe);
  modport host_mp (input scl, input sda, output hostSclOut, output hostSclOe,
                   output hostSdaOut, output hostSdaOe);
endinterface : cgi_link_if

// ---- src/cgi_target.sv ----
`timescale 1ns/1ps
// Operation
// - Write: start, address+W, ack, index, ack
// - Block write count byte follows index, acked
// - Data bytes acked, stored at rising index
// - Controller ends block write with stop
// - Read: set index, repeated start, address+R
// - Target sends count byte, then indexed data
// - Controller acks every byte except last
// - Last byte nacked, then stop; release line
// - Bits 6:5 select write address D0..D6
// - Bit 7 flags memory programmed
// - Bit 4 enables first loop spread
// - Bit 2 selects third loop reference
// - Bit 0 locks memory against writes
// - Serial clock up to 400 kHz
// - Spread is downward only, programmable amount
module cgi_target #(
  parameter int REG_COUNT = cgi_pkg::REG_COUNT
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               clkEn,
  cgi_link_if.dev_mp              link,
  output logic [REG_COUNT*8-1:0]  cfgBytes,
  output logic [6:0]              busAddress,
  output logic                    otpProgrammed,
  output logic                    firstLoopSpreadEnable,
  output logic                    thirdLoopReferenceSelect,
  output logic                    otpWriteLock
);

  localparam int         IW  = $clog2(REG_COUNT);
  localparam logic [7:0] RC8 = 8'(REG_COUNT);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA, ST_RDATA, ST_IGNORE
  } cgi_dev_state_e;

  cgi_dev_state_e state_q;
  logic           sclPrev_q;
  logic           sdaPrev_q;
  logic [3:0]     bitCnt_q;
  logic           ackPhase_q;
  logic [7:0]     shift_q;
  logic [7:0]     txShift_q;
  logic           sdaOe_q;
  logic           hostAck_q;
  logic [7:0]     index_q;
  logic [7:0]     remain_q;
  logic [7:0]     regs_q [REG_COUNT];
  logic           sclRise;
  logic           sclFall;
  logic           startSeen;
  logic           stopSeen;
  logic           byteDone;
  logic           ackEnd;
  logic           inRange;
  logic           accept;
  logic           wrEn;
  logic [7:0]     readByte;
  logic [7:0]     countByte;

  ////////////////////////////////////////////////////////////////////////////
  // Line sampling; pins are synchronous to clock, so no synchroniser here.
  // About 78 system clocks per quarter at 400 kHz leave wide margin.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else if (clkEn) begin
      sclPrev_q <= link.scl;
      sdaPrev_q <= link.sda;
    end
  end

  // Edges and bus conditions
  assign sclRise   = link.scl & ~sclPrev_q;
  assign sclFall   = ~link.scl & sclPrev_q;
  assign startSeen = link.scl & sclPrev_q & sdaPrev_q & ~link.sda;
  assign stopSeen  = link.scl & sclPrev_q & ~sdaPrev_q & link.sda;
  assign byteDone  = sclFall & ~ackPhase_q & (bitCnt_q == 4'd8);
  assign ackEnd    = sclFall & ackPhase_q;

  // Bytes past the bank read as zero and drop writes
  assign inRange   = index_q < RC8;
  assign readByte  = inRange ? regs_q[index_q[IW-1:0]] : 8'h00;
  assign countByte = inRange ? RC8 - index_q : 8'h00;

  // Whether the byte just shifted in earns an acknowledge
  always_comb begin
    case (state_q)
      ST_ADDR:  accept = (shift_q[7:1] == busAddress);
      ST_WDATA: accept = (remain_q != 8'h00);
      default:  accept = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer; SDA only ever changes while SCL is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      bitCnt_q   <= 4'h0;
      ackPhase_q <= 1'b0;
      shift_q    <= 8'h00;
      txShift_q  <= 8'h00;
      sdaOe_q    <= 1'b0;
      hostAck_q  <= 1'b0;
      index_q    <= 8'h00;
      remain_q   <= 8'h00;
    end else if (clkEn) begin
      if (startSeen) begin
        // Start or repeated start always reopens address phase
        state_q    <= ST_ADDR;
        bitCnt_q   <= 4'h0;
        ackPhase_q <= 1'b0;
        sdaOe_q    <= 1'b0;
      end else if (stopSeen) begin
        state_q    <= ST_IDLE;
        ackPhase_q <= 1'b0;
        sdaOe_q    <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE, ST_IGNORE: begin
            sdaOe_q <= 1'b0;
          end
          ST_RDATA: begin
            if (!ackPhase_q) begin
              if (sclRise) begin
                bitCnt_q <= bitCnt_q + 4'd1;
              end else if (sclFall) begin
                if (bitCnt_q == 4'd8) begin
                  // Let go so the controller can answer
                  ackPhase_q <= 1'b1;
                  sdaOe_q    <= 1'b0;
                end else begin
                  sdaOe_q   <= ~txShift_q[7];
                  txShift_q <= {txShift_q[6:0], 1'b0};
                end
              end
            end else if (sclRise) begin
              hostAck_q <= ~link.sda;
            end else if (sclFall) begin
              if (hostAck_q) begin
                // Next register; index moves on after each fetch
                ackPhase_q <= 1'b0;
                bitCnt_q   <= 4'h0;
                sdaOe_q    <= ~readByte[7];
                txShift_q  <= {readByte[6:0], 1'b0};
                index_q    <= index_q + 8'd1;
              end else begin
                state_q <= ST_IGNORE;
                sdaOe_q <= 1'b0;
              end
            end
          end
          default: begin
            if (!ackPhase_q) begin
              if (sclRise) begin
                shift_q  <= {shift_q[6:0], link.sda};
                bitCnt_q <= bitCnt_q + 4'd1;
              end else if (byteDone) begin
                ackPhase_q <= 1'b1;
                bitCnt_q   <= 4'h0;
                sdaOe_q    <= accept;
                if (!accept) begin
                  state_q <= ST_IGNORE;
                end
              end
            end else if (ackEnd) begin
              ackPhase_q <= 1'b0;
              sdaOe_q    <= 1'b0;
              case (state_q)
                ST_ADDR: begin
                  if (shift_q[0]) begin
                    // Read: count goes out first
                    state_q   <= ST_RDATA;
                    sdaOe_q   <= ~countByte[7];
                    txShift_q <= {countByte[6:0], 1'b0};
                  end else begin
                    state_q <= ST_INDEX;
                  end
                end
                ST_INDEX: begin
                  index_q <= shift_q;
                  state_q <= ST_COUNT;
                end
                ST_COUNT: begin
                  remain_q <= shift_q;
                  state_q  <= ST_WDATA;
                end
                ST_WDATA: begin
                  index_q  <= index_q + 8'd1;
                  remain_q <= remain_q - 8'd1;
                end
                default: begin
                  state_q <= ST_IGNORE;
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bank; a byte lands at the end of its acknowledge bit
  assign wrEn = clkEn & ackEnd & (state_q == ST_WDATA) & inRange;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= (i == 0) ? cgi_pkg::GCTRL_RESET : cgi_pkg::CFG_RESET;
      end
    end else if (wrEn) begin
      // Reserved control bits stay zero whatever is written
      if (index_q == cgi_pkg::GCTRL_IDX) begin
        regs_q[index_q[IW-1:0]] <= shift_q & cgi_pkg::GCTRL_WMASK;
      end else begin
        regs_q[index_q[IW-1:0]] <= shift_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control byte fields to the clock core
  assign busAddress = cgi_pkg::DEV_ADDR_BASE |
                      {5'h00, regs_q[0][cgi_pkg::GC_ADDR_MSB:cgi_pkg::GC_ADDR_LSB]};
  assign otpProgrammed            = regs_q[0][cgi_pkg::GC_OTP_DONE];
  // Only the enable lives here; the downward amount sits in the loop bytes
  assign firstLoopSpreadEnable    = regs_q[0][cgi_pkg::GC_SPREAD];
  assign thirdLoopReferenceSelect = regs_q[0][cgi_pkg::GC_REFSEL];
  // Memory controller must refuse programming while this is high
  assign otpWriteLock             = regs_q[0][cgi_pkg::GC_LOCK];

  // Whole bank flattened, byte 0 in the low lane
  for (genvar g = 0; g < REG_COUNT; g++) begin : gPack
    assign cfgBytes[g*8 +: 8] = regs_q[g];
  end

  // Open drain: we only ever pull low
  assign link.devSdaOut = 1'b0;
  assign link.devSdaOe  = sdaOe_q;

endmodule : cgi_target

// ---- src/cgi_controller.sv ----
`timescale 1ns/1ps
module cgi_controller #(
  parameter int QTR_CYCLES = cgi_pkg::QTR_CYC,
  parameter int BUF_DEPTH  = cgi_pkg::HOST_BUF_DEPTH
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  cgi_link_if.host_mp      link,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [7:0]       regRdata,
  output logic             busy
);

  localparam int BW = $clog2(BUF_DEPTH);

  typedef enum logic [3:0] {
    H_IDLE, H_START, H_ADDRW, H_INDEX, H_COUNT, H_WDATA,
    H_RSTART, H_ADDRR, H_RCOUNT, H_RDATA, H_STOP
  } cgi_host_state_e;

  cgi_host_state_e state_q;
  logic [15:0]     div_q;
  logic [1:0]      qtr_q;
  logic [3:0]      bit_q;
  logic [6:0]      target_q;
  logic [7:0]      index_q;
  logic [7:0]      count_q;
  logic [7:0]      rxCount_q;
  logic [7:0]      ptr_q;
  logic [7:0]      rxShift_q;
  logic            readMode_q;
  logic            ackIn_q;
  logic            nack_q;
  logic            sclOe_q;
  logic            sdaOe_q;
  logic [7:0]      buf_q [BUF_DEPTH];
  logic            tick;
  logic            symEnd;
  logic            isFrame;
  logic            isRx;
  logic            lastByte;
  logic            idleWr;
  logic [7:0]      txByte;
  logic            sclLvl;
  logic            sdaLvl;

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-bit timing; four quarters per serial clock period
  assign tick     = (div_q == 16'(QTR_CYCLES - 1));
  assign symEnd   = tick & (qtr_q == 2'd3);
  assign isFrame  = (state_q == H_START) | (state_q == H_RSTART) | (state_q == H_STOP);
  assign isRx     = (state_q == H_RCOUNT) | (state_q == H_RDATA);
  assign lastByte = (ptr_q == count_q - 8'd1);
  assign idleWr   = regWr & (state_q == H_IDLE);
  assign busy     = (state_q != H_IDLE);

  // Byte to shift out for the current phase
  always_comb begin
    case (state_q)
      H_ADDRW: txByte = {target_q, 1'b0};
      H_ADDRR: txByte = {target_q, 1'b1};
      H_INDEX: txByte = index_q;
      H_COUNT: txByte = count_q;
      H_WDATA: txByte = buf_q[ptr_q[BW-1:0]];
      default: txByte = 8'hff;
    endcase
  end

  // Line levels per quarter; release means high
  always_comb begin
    sclLvl = 1'b1;
    sdaLvl = 1'b1;
    case (state_q)
      H_IDLE: begin
        sclLvl = 1'b1;
      end
      H_START, H_RSTART: begin
        sclLvl = (qtr_q == 2'd1) | (qtr_q == 2'd2);
        sdaLvl = ~qtr_q[1];
      end
      H_STOP: begin
        sclLvl = (qtr_q != 2'd0);
        sdaLvl = qtr_q[1];
      end
      default: begin
        sclLvl = (qtr_q == 2'd1) | (qtr_q == 2'd2);
        if (bit_q == 4'd8) begin
          // Acknowledge slot: answer when reading, listen when writing
          sdaLvl = isRx ? ~((state_q == H_RCOUNT) ? (count_q != 8'h00) : ~lastByte) : 1'b1;
        end else begin
          sdaLvl = isRx | txByte[3'd7 - bit_q[2:0]];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit engine: divider, quarter, bit count, sampling, pin flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q     <= 16'h0000;
      qtr_q     <= 2'd0;
      bit_q     <= 4'h0;
      rxShift_q <= 8'h00;
      ackIn_q   <= 1'b0;
      sclOe_q   <= 1'b0;
      sdaOe_q   <= 1'b0;
    end else if (clkEn) begin
      sclOe_q <= ~sclLvl;
      sdaOe_q <= ~sdaLvl;
      if (state_q == H_IDLE) begin
        div_q <= 16'h0000;
        qtr_q <= 2'd0;
        bit_q <= 4'h0;
      end else begin
        div_q <= tick ? 16'h0000 : div_q + 16'h0001;
        if (tick) begin
          qtr_q <= qtr_q + 2'd1;
        end
        // Sample at the end of the high half
        if (tick && qtr_q == 2'd2 && !isFrame) begin
          if (bit_q == 4'd8) begin
            ackIn_q <= ~link.sda;
          end else begin
            rxShift_q <= {rxShift_q[6:0], link.sda};
          end
        end
        if (symEnd) begin
          bit_q <= (isFrame || bit_q == 4'd8) ? 4'h0 : bit_q + 4'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte sequencer; a missing acknowledge aborts straight to stop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= H_IDLE;
      ptr_q      <= 8'h00;
      readMode_q <= 1'b0;
      nack_q     <= 1'b0;
      rxCount_q  <= 8'h00;
    end else if (clkEn) begin
      if (state_q == H_IDLE) begin
        if (idleWr && regAddr == cgi_pkg::HR_CMD && regWdata[cgi_pkg::CMD_GO]) begin
          state_q    <= H_START;
          readMode_q <= regWdata[cgi_pkg::CMD_READ];
          nack_q     <= 1'b0;
          ptr_q      <= 8'h00;
        end
      end else if (symEnd && (isFrame || bit_q == 4'd8)) begin
        case (state_q)
          H_START:  state_q <= H_ADDRW;
          H_RSTART: state_q <= H_ADDRR;
          H_STOP:   state_q <= H_IDLE;
          H_RCOUNT: begin
            rxCount_q <= rxShift_q;
            state_q   <= (count_q == 8'h00) ? H_STOP : H_RDATA;
          end
          H_RDATA: begin
            ptr_q   <= ptr_q + 8'd1;
            state_q <= lastByte ? H_STOP : H_RDATA;
          end
          default: begin
            if (!ackIn_q) begin
              nack_q  <= 1'b1;
              state_q <= H_STOP;
            end else begin
              case (state_q)
                H_ADDRW: state_q <= H_INDEX;
                H_INDEX: state_q <= readMode_q ? H_RSTART : H_COUNT;
                H_COUNT: state_q <= (count_q == 8'h00) ? H_STOP : H_WDATA;
                H_WDATA: begin
                  ptr_q   <= ptr_q + 8'd1;
                  state_q <= lastByte ? H_STOP : H_WDATA;
                end
                H_ADDRR: state_q <= H_RCOUNT;
                default: state_q <= H_STOP;
              endcase
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; setup is frozen while a transfer runs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      target_q <= 7'h00;
      index_q  <= 8'h00;
      count_q  <= 8'h00;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (clkEn) begin
      if (state_q == H_RDATA && symEnd && bit_q == 4'd8) begin
        buf_q[ptr_q[BW-1:0]] <= rxShift_q;
      end else if (idleWr) begin
        if (regAddr == cgi_pkg::HR_TARGET) target_q <= regWdata[6:0];
        if (regAddr == cgi_pkg::HR_INDEX) index_q <= regWdata;
        if (regAddr == cgi_pkg::HR_COUNT) count_q <= regWdata;
        if (regAddr >= cgi_pkg::HR_BUF && regAddr < cgi_pkg::HR_BUF + 8'(BUF_DEPTH)) begin
          buf_q[regAddr[BW-1:0]] <= regWdata;
        end
      end
    end
  end

  // Read data stand in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (clkEn && regRd) begin
      if (regAddr == cgi_pkg::HR_STATUS) regRdata <= {6'h00, nack_q, busy};
      else if (regAddr == cgi_pkg::HR_TARGET) regRdata <= {1'b0, target_q};
      else if (regAddr == cgi_pkg::HR_INDEX) regRdata <= index_q;
      else if (regAddr == cgi_pkg::HR_COUNT) regRdata <= count_q;
      else if (regAddr == cgi_pkg::HR_RXCOUNT) regRdata <= rxCount_q;
      else if (regAddr >= cgi_pkg::HR_BUF && regAddr < cgi_pkg::HR_BUF + 8'(BUF_DEPTH)) regRdata <= buf_q[regAddr[BW-1:0]];
      else regRdata <= 8'h00;
    end
  end

  assign link.hostSclOut = 1'b0;
  assign link.hostSclOe  = sclOe_q;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOe  = sdaOe_q;

endmodule : cgi_controller

// ---- test/cgi_link_props.sv ----
`timescale 1ns/1ps
module cgi_link_props #(
  parameter int QTR = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hostSdaOe,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  input wire logic scl,
  input wire logic sda
);
  int   runLen_q;
  logic sclPrev_q;
  logic sclEdge;

  ////////////////////////////////////////////////////////////////////////////
  // Length of the current clock level; idle bus counts as long enough
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      runLen_q  <= 2 * QTR;
      sclPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= scl;
      runLen_q  <= sclEdge ? 1 : runLen_q + 1;
    end
  end
  assign sclEdge = scl != sclPrev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Wire-level rules, all in the single clock domain
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_devOd; devSdaOe |-> !devSdaOut; endproperty
  a_devOd: assert property (p_devOd) else $error("target drives sda high");
  property p_devRise; $rose(devSdaOe) |-> !scl; endproperty
  a_devRise: assert property (p_devRise) else $error("target pulls sda with scl high");
  property p_devHold; scl && $past(scl) |-> $stable(devSdaOe); endproperty
  a_devHold: assert property (p_devHold) else $error("target sda moved in high phase");
  property p_stopRel; $rose(sda) && scl && $past(scl) |-> !devSdaOe; endproperty
  a_stopRel: assert property (p_stopRel) else $error("target holds sda at stop");
  property p_startHost; $fell(sda) && scl && $past(scl) |-> hostSdaOe && !devSdaOe; endproperty
  a_startHost: assert property (p_startHost) else $error("start not made by controller");
  property p_devBound; $rose(devSdaOe) |-> ##[1:400] !devSdaOe; endproperty
  a_devBound: assert property (p_devBound) else $error("target never releases sda");
  property p_sclHigh; sclEdge && !scl |-> runLen_q >= 2 * QTR - 1; endproperty
  a_sclHigh: assert property (p_sclHigh) else $error("scl high phase too short");
  property p_sclLow; sclEdge && scl |-> runLen_q >= QTR - 1; endproperty
  a_sclLow: assert property (p_sclLow) else $error("scl low phase too short");
  c_devDrive: cover property ($rose(devSdaOe));
  c_stop: cover property ($rose(sda) && scl);
  c_fall: cover property (sclEdge && !scl);
endmodule : cgi_link_props

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic                            clock = 1'b0;
  logic                            rst_n = 1'b0;
  logic [7:0]                      regAddr = 8'h00;
  logic [7:0]                      regWdata = 8'h00;
  logic                            regWr = 1'b0;
  logic                            regRd = 1'b0;
  logic                            rdSeen = 1'b0;
  logic [7:0]                      regRdata;
  logic                            busy;
  logic [cgi_pkg::REG_COUNT*8-1:0] cfgBytes;
  logic [6:0]                      busAddress;
  logic [6:0]                      cur;
  wire logic [3:0]                 flags;
  logic [31:0]                     seed = 32'h29;
  logic [7:0]                      mem [16];
  logic [7:0]                      expQ [$];
  int                              mismatches = 0;
  int                              total_checks = 0;
  cgi_link_if link ();

  cgi_target i_cgi_target (.clock(clock), .rst_n(rst_n), .clkEn(1'b1), .link(link), .cfgBytes(cfgBytes),
    .busAddress(busAddress), .otpProgrammed(flags[3]), .firstLoopSpreadEnable(flags[2]),
    .thirdLoopReferenceSelect(flags[1]), .otpWriteLock(flags[0]));
  cgi_controller #(.QTR_CYCLES(8)) i_cgi_controller (.clock(clock), .rst_n(rst_n), .clkEn(1'b1),
    .link(link), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .busy(busy));
  cgi_link_props #(.QTR(8)) i_cgi_link_props (.clock(clock), .rst_n(rst_n), .hostSdaOe(link.hostSdaOe),
    .devSdaOut(link.devSdaOut), .devSdaOe(link.devSdaOe), .scl(link.scl), .sda(link.sda));

  always #4 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  // One strobe cycle; a read notes its expected answer d
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    if (wr) begin
      regWr <= 1'b1;
    end else begin
      regRd <= 1'b1;
      expQ.push_back(d);
    end
    @(posedge clock);
    regWr <= 1'b0;
    regRd <= 1'b0;
  endtask : bus

  // Whole bus transaction; busy is polled at falling edges, bounded
  task automatic xfer(input logic rdDir, input logic [6:0] tgt, input logic [7:0] idx, input int n);
    int k;
    bus(1'b1, cgi_pkg::HR_TARGET, {1'b0, tgt});
    bus(1'b1, cgi_pkg::HR_INDEX, idx);
    bus(1'b1, cgi_pkg::HR_COUNT, 8'(n));
    bus(1'b1, cgi_pkg::HR_CMD, {6'h00, rdDir, 1'b1});
    repeat (3) @(negedge clock);
    k = 0;
    while (busy !== 1'b0 && k < 20000) begin
      @(negedge clock);
      k++;
    end
    if (k == 20000) begin
      mismatches++;
      $display("BAD %0t: transfer hung", $time);
      test_done();
    end
  endtask : xfer

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  // Read answers stand one cycle after the strobe; oldest note first
  always @(posedge clock) begin
    rdSeen <= regRd;
    if (rdSeen && expQ.size() > 0) cmp(regRdata, expQ.pop_front());
  end

  // Watchdog, far above the expected run length
  initial begin
    repeat (80000) @(posedge clock);
    mismatches++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    cur = 7'h68;
    @(negedge clock);
    cmp({1'b0, busAddress}, 8'h68);
    cmp({flags, 4'h0}, 8'h00);
    // Full bank write; reserved bits of byte 0 must read back 0
    bus(1'b1, cgi_pkg::HR_BUF, 8'h9f);
    for (int i = 1; i < 16; i++) begin
      mem[i] = rnd();
      bus(1'b1, cgi_pkg::HR_BUF + 8'(i), mem[i]);
    end
    mem[0] = 8'h95;
    xfer(1'b0, cur, 8'h00, 16);
    bus(1'b0, cgi_pkg::HR_STATUS, 8'h00);
    cmp({flags, 4'h0}, 8'hf0);
    for (int i = 0; i < 16; i++) cmp(cfgBytes[8*i+:8], mem[i]);
    // Read at the top of the bank: count byte is what remains
    xfer(1'b1, cur, 8'h0d, 3);
    bus(1'b0, cgi_pkg::HR_RXCOUNT, 8'h03);
    for (int i = 0; i < 3; i++) bus(1'b0, cgi_pkg::HR_BUF + 8'(i), mem[13+i]);
    bus(1'b0, cgi_pkg::HR_STATUS, 8'h00);
    // Every address code, each written through the previous address
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, cgi_pkg::HR_BUF, 8'(c << 5));
      xfer(1'b0, cur, 8'h00, 1);
      cur = 7'h68 | 7'(c);
      cmp({1'b0, busAddress}, {1'b0, cur});
    end
    // Stale address is ignored and nacked
    bus(1'b1, cgi_pkg::HR_BUF, 8'h11);
    xfer(1'b0, 7'h68, 8'h00, 1);
    bus(1'b0, cgi_pkg::HR_STATUS, 8'h02);
    cmp(cfgBytes[7:0], 8'h60);
    repeat (4) @(posedge clock);
    test_done();
  end
endmodule : testbench
